//--- rtl/asc_top.sv
// serial readout and configuration port of a magnetic angle encoder
// assumes an external mode 3 master; link pins are asynchronous to REF_CLK_I
// Behaviour
// - device is only a slave; master drives select, clock and data in
// - mode 3: clock idles high, sample on rising edge, msb first
// - a standard select-low transfer moves 16 bits in each direction; an extended one sends 24 out but takes only 16 in
// - extended transfer yields 24 bits: 16 angle (read data then a zero byte after a read) then 8-bit time index
// - quadrature output A, B and index with 10-bit resolution per turn
// - 8-bit bias trim amount held at address 0x3
// - 12-bit zero offset: high byte at 0x4, low nibble at 0x5
// - x trim enable reduces x-axis bias by trim amount
// - y trim enable reduces y-axis bias by trim amount
// - address 0x9 bits 5..3 commit register n to nonvolatile storage
// - zero defaults to zero; output angle is raw minus zero
// - both enables reduce both axes equally
`timescale 1ns/1ps
`default_nettype none

module asc_top
(
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_SCLK_I,
    input wire logic SPI_MOSI_I,
    output logic SPI_MISO_O,
    output logic SPI_MISO_OE_O,
    input wire logic [15:0] RAW_ANGLE_I,
    input wire logic RAW_VALID_I,
    output logic [15:0] ANGLE_O,
    output logic [7:0] TRIM_X_O,
    output logic [7:0] TRIM_Y_O,
    output logic [2:0] FLASH_COMMIT_O,
    output logic QUAD_A_O,
    output logic QUAD_B_O,
    output logic QUAD_INDEX_O
);

    // synchronisers: first stage feeds only the second
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic mosi_m;
    logic mosi_s;

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    // link state
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [15:0] rx_sh;
    logic [15:0] next_rx_sh;
    logic [23:0] tx_sh;
    logic [23:0] next_tx_sh;
    logic miso;
    logic next_miso;
    logic miso_oe;
    logic next_miso_oe;
    logic rd_pend;
    logic next_rd_pend;
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;

    // settings, written by the link, applied at measurement, except the flash commit pulse
    logic [7:0] bias_trim_amount;
    logic [7:0] next_bias_trim_amount;
    logic [11:0] zero_offset;
    logic [11:0] next_zero_offset;
    logic trim_x_enable;
    logic next_trim_x_enable;
    logic trim_y_enable;
    logic next_trim_y_enable;
    logic [2:0] flash_commit_bit;
    logic [2:0] next_flash_commit_bit;

    // measurement side
    logic [15:0] angle;
    logic [15:0] next_angle;
    logic [7:0] time_idx;
    logic [7:0] next_time_idx;
    logic [7:0] trim_x;
    logic [7:0] next_trim_x;
    logic [7:0] trim_y;
    logic [7:0] next_trim_y;

    logic wr_now;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    function automatic logic [7:0] reg_read(
        input logic [3:0] addr,
        input logic [7:0] trim_amt,
        input logic [11:0] zero,
        input logic tx_en,
        input logic ty_en
    );
        logic [7:0] val;
        val = 8'h00;
        unique case (addr)
            asc_pkg::ADDR_BIAS_TRIM: val = trim_amt;
            asc_pkg::ADDR_ZERO_HIGH: val = zero[11:4];
            asc_pkg::ADDR_TRIM_ZERO_LOW: val = {2'b00, ty_en, tx_en, zero[3:0]};
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
            sclk_m <= 1'b1;
            sclk_s <= 1'b1;
            sclk_d <= 1'b1;
            mosi_m <= 1'b0;
            mosi_s <= 1'b0;
        end
        else
        begin
            cs_m <= SPI_CS_N_I;
            cs_s <= cs_m;
            cs_d <= cs_s;
            sclk_m <= SPI_SCLK_I;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            mosi_m <= SPI_MOSI_I;
            mosi_s <= mosi_m;
        end
    end

    // edges seen two cycles late; link clock must stay well below REF_CLK_I / 4
    always_comb
    begin
        sclk_rise = sclk_s & ~sclk_d;
        sclk_fall = ~sclk_s & sclk_d;
        cs_fall = ~cs_s & cs_d;
        cs_rise = cs_s & ~cs_d;
        // a short frame is dropped whole rather than half applied
        wr_now = cs_rise && (bit_cnt >= asc_pkg::WORD_CNT)
            && (rx_sh[asc_pkg::OP_MSB:asc_pkg::OP_LSB] == asc_pkg::OP_WRITE);
        wr_addr = rx_sh[asc_pkg::ADDR_MSB:asc_pkg::ADDR_LSB];
        wr_data = rx_sh[asc_pkg::DATA_MSB:0];
    end

    always_comb
    begin
        next_bit_cnt = bit_cnt;
        next_rx_sh = rx_sh;
        next_tx_sh = tx_sh;
        next_miso = miso;
        next_miso_oe = ~cs_s;
        next_rd_pend = rd_pend;
        next_rd_data = rd_data;
        next_bias_trim_amount = bias_trim_amount;
        next_zero_offset = zero_offset;
        next_trim_x_enable = trim_x_enable;
        next_trim_y_enable = trim_y_enable;
        next_flash_commit_bit = 3'h0;
        next_angle = angle;
        next_time_idx = time_idx;
        next_trim_x = trim_x;
        next_trim_y = trim_y;
        if (cs_fall)
        begin
            next_bit_cnt = 5'h00;
            next_rd_pend = 1'b0;
            // read answer replaces the angle word, time index still follows
            next_tx_sh = rd_pend ? {rd_data, 8'h00, time_idx} : {angle, time_idx};
            next_miso = next_tx_sh[asc_pkg::EXT_BITS-1];
        end
        else if (!cs_s)
        begin
            if (sclk_rise && bit_cnt < asc_pkg::EXT_CNT)
            begin
                next_bit_cnt = bit_cnt + 5'h01;
                if (bit_cnt < asc_pkg::WORD_CNT)
                begin
                    next_rx_sh = {rx_sh[asc_pkg::WORD_BITS-2:0], mosi_s};
                end
            end
            // first falling edge only presents the msb already out
            if (sclk_fall && bit_cnt != 5'h00)
            begin
                next_tx_sh = {tx_sh[asc_pkg::EXT_BITS-2:0], 1'b0};
                next_miso = tx_sh[asc_pkg::EXT_BITS-2];
            end
        end

        if (cs_rise && bit_cnt >= asc_pkg::WORD_CNT
            && rx_sh[asc_pkg::OP_MSB:asc_pkg::OP_LSB] == asc_pkg::OP_READ)
        begin
            next_rd_pend = 1'b1;
            next_rd_data = reg_read(wr_addr, bias_trim_amount, zero_offset, trim_x_enable, trim_y_enable);
        end

        if (wr_now)
        begin
            unique case (wr_addr)
                asc_pkg::ADDR_BIAS_TRIM: next_bias_trim_amount = wr_data;
                asc_pkg::ADDR_ZERO_HIGH: next_zero_offset = {wr_data, zero_offset[3:0]};
                asc_pkg::ADDR_TRIM_ZERO_LOW:
                begin
                    next_zero_offset = {zero_offset[11:4], wr_data[asc_pkg::ZERO_LOW_MSB:0]};
                    next_trim_x_enable = wr_data[asc_pkg::TRIM_X_BIT];
                    next_trim_y_enable = wr_data[asc_pkg::TRIM_Y_BIT];
                end
                asc_pkg::ADDR_FLASH:
                    next_flash_commit_bit = wr_data[asc_pkg::FLASH_R5_BIT:asc_pkg::FLASH_R3_BIT];
                default: next_flash_commit_bit = 3'h0;
            endcase
        end

        // trim and zero settings reach the outputs only at a measurement boundary
        if (RAW_VALID_I)
        begin
            next_angle = RAW_ANGLE_I - {zero_offset, 4'h0};
            next_time_idx = time_idx + 8'h01;
            next_trim_x = trim_x_enable ? bias_trim_amount : 8'h00;
            next_trim_y = trim_y_enable ? bias_trim_amount : 8'h00;
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            bit_cnt <= 5'h00;
            rx_sh <= 16'h0000;
            tx_sh <= 24'h00_0000;
            miso <= 1'b0;
            miso_oe <= 1'b0;
            rd_pend <= 1'b0;
            rd_data <= 8'h00;
            bias_trim_amount <= asc_pkg::BIAS_TRIM_RST;
            zero_offset <= asc_pkg::ZERO_RST;
            trim_x_enable <= asc_pkg::TRIM_EN_RST;
            trim_y_enable <= asc_pkg::TRIM_EN_RST;
            flash_commit_bit <= 3'h0;
            angle <= asc_pkg::ANGLE_RST;
            time_idx <= asc_pkg::TIME_RST;
            trim_x <= 8'h00;
            trim_y <= 8'h00;
        end
        else
        begin
            bit_cnt <= next_bit_cnt;
            rx_sh <= next_rx_sh;
            tx_sh <= next_tx_sh;
            miso <= next_miso;
            miso_oe <= next_miso_oe;
            rd_pend <= next_rd_pend;
            rd_data <= next_rd_data;
            bias_trim_amount <= next_bias_trim_amount;
            zero_offset <= next_zero_offset;
            trim_x_enable <= next_trim_x_enable;
            trim_y_enable <= next_trim_y_enable;
            flash_commit_bit <= next_flash_commit_bit;
            angle <= next_angle;
            time_idx <= next_time_idx;
            trim_x <= next_trim_x;
            trim_y <= next_trim_y;
        end
    end

    assign SPI_MISO_O = miso;
    assign SPI_MISO_OE_O = miso_oe;
    assign ANGLE_O = angle;
    assign TRIM_X_O = trim_x;
    assign TRIM_Y_O = trim_y;
    assign FLASH_COMMIT_O = flash_commit_bit;

    asc_quad u_quad
    (
        .clk_i(REF_CLK_I),
        .rst_i(SYS_RST_I),
        .target_i(angle[15:6]),
        .phase_a_o(QUAD_A_O),
        .phase_b_o(QUAD_B_O),
        .index_o(QUAD_INDEX_O)
    );

    default clocking dcb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    a_release_miso_idle: assert property (cs_s ##1 cs_s |=> !SPI_MISO_OE_O)
        else $error("data out driven while deselected");
    a_mosi_rise_sample: assert property (!cs_s && !cs_fall && sclk_rise && bit_cnt < asc_pkg::WORD_CNT
        |=> rx_sh[0] == $past(mosi_s) && bit_cnt == $past(bit_cnt) + 5'h01)
        else $error("data in not sampled on rising edge");
    a_miso_fall_shift: assert property (!cs_s && !cs_fall && sclk_fall && bit_cnt != 5'h00
        |=> SPI_MISO_O == $past(tx_sh[22]))
        else $error("data out did not advance on falling edge");
    a_frame_time_tail: assert property (cs_fall && !rd_pend
        |=> tx_sh == {$past(angle), $past(time_idx)} && SPI_MISO_O == $past(angle[15]))
        else $error("frame load wrong");
    a_short_frame_drop: assert property (cs_rise && bit_cnt < asc_pkg::WORD_CNT
        |=> $stable(bias_trim_amount) && $stable(zero_offset))
        else $error("short frame changed settings");
    a_bias_write: assert property (wr_now && wr_addr == asc_pkg::ADDR_BIAS_TRIM
        |=> bias_trim_amount == $past(wr_data))
        else $error("bias trim write lost");
    a_zero_low_write: assert property (wr_now && wr_addr == asc_pkg::ADDR_TRIM_ZERO_LOW
        |=> zero_offset[3:0] == $past(wr_data[3:0]) && zero_offset[11:4] == $past(zero_offset[11:4])
            && trim_x_enable == $past(wr_data[4]) && trim_y_enable == $past(wr_data[5]))
        else $error("zero low write wrong");
    a_trim_x_apply: assert property (RAW_VALID_I
        |=> TRIM_X_O == ($past(trim_x_enable) ? $past(bias_trim_amount) : 8'h00))
        else $error("x trim not applied");
    a_trim_y_apply: assert property (RAW_VALID_I
        |=> TRIM_Y_O == ($past(trim_y_enable) ? $past(bias_trim_amount) : 8'h00))
        else $error("y trim not applied");
    a_trim_both_equal: assert property (RAW_VALID_I && trim_x_enable && trim_y_enable
        |=> TRIM_X_O == $past(bias_trim_amount) && TRIM_Y_O == $past(bias_trim_amount))
        else $error("axes trimmed unequally");
    a_flash_pulse_once: assert property (wr_now && wr_addr == asc_pkg::ADDR_FLASH
        |=> FLASH_COMMIT_O == $past(wr_data[5:3]) ##1 FLASH_COMMIT_O == 3'h0)
        else $error("flash commit pulse wrong");
    a_angle_zero_sub: assert property (RAW_VALID_I
        |=> ANGLE_O == $past(RAW_ANGLE_I) - {$past(zero_offset), 4'h0})
        else $error("angle offset wrong");
    a_hold_between_meas: assert property (!RAW_VALID_I
        |=> $stable(ANGLE_O) && $stable(TRIM_X_O) && $stable(TRIM_Y_O))
        else $error("output changed between measurements");

endmodule

`default_nettype wire

//--- rtl/asc_pkg.sv
// constants shared by the angle sensor serial port and its quadrature output
// assumes one 100 MHz system clock; all link pins are sampled by that clock
package asc_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned QUAD_STEP_NS = 50;
    localparam int unsigned QUAD_STEP_CYC = (QUAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // frame sizes
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned EXT_BITS = 24;
    localparam int unsigned TIME_BITS = 8;
    localparam int unsigned QUAD_BITS = 10;
    localparam logic [4:0] WORD_CNT = 5'h10;
    localparam logic [4:0] EXT_CNT = 5'h18;

    // command word layout: opcode, address, data
    localparam int unsigned OP_MSB = 15;
    localparam int unsigned OP_LSB = 12;
    localparam int unsigned ADDR_MSB = 11;
    localparam int unsigned ADDR_LSB = 8;
    localparam int unsigned DATA_MSB = 7;
    localparam logic [3:0] OP_WRITE = 4'h8;
    localparam logic [3:0] OP_READ = 4'h4;

    // register offsets
    localparam logic [3:0] ADDR_BIAS_TRIM = 4'h3;
    localparam logic [3:0] ADDR_ZERO_HIGH = 4'h4;
    localparam logic [3:0] ADDR_TRIM_ZERO_LOW = 4'h5;
    localparam logic [3:0] ADDR_FLASH = 4'h9;

    // field positions
    localparam int unsigned ZERO_LOW_MSB = 3;
    localparam int unsigned TRIM_X_BIT = 4;
    localparam int unsigned TRIM_Y_BIT = 5;
    localparam int unsigned FLASH_R3_BIT = 3;
    localparam int unsigned FLASH_R5_BIT = 5;

    // reset values
    localparam logic [7:0] BIAS_TRIM_RST = 8'h00;
    localparam logic [11:0] ZERO_RST = 12'h000;
    localparam logic TRIM_EN_RST = 1'b0;
    localparam logic [15:0] ANGLE_RST = 16'h0000;
    localparam logic [7:0] TIME_RST = 8'h00;
    localparam logic [9:0] QUAD_RST = 10'h000;

endpackage

//--- rtl/asc_quad.sv
// quadrature incremental output, 1024 edges per turn
// assumes target position updates from the same clock as the stepping divider
`timescale 1ns/1ps
`default_nettype none

module asc_quad
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [9:0] target_i,
    output logic phase_a_o,
    output logic phase_b_o,
    output logic index_o
);

    logic [2:0] div;
    logic [2:0] next_div;
    logic [9:0] pos;
    logic [9:0] next_pos;
    logic [9:0] diff;
    logic step_en;

    // one edge per step, shortest way round, so fast moves lag but never skip phase
    always_comb
    begin
        step_en = (div == 3'(asc_pkg::QUAD_STEP_CYC - 1));
        next_div = step_en ? 3'h0 : div + 3'h1;
        diff = target_i - pos;
        next_pos = pos;
        if (step_en && diff != 10'h000)
        begin
            next_pos = diff[9] ? pos - 10'h001 : pos + 10'h001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div <= 3'h0;
            pos <= asc_pkg::QUAD_RST;
            phase_a_o <= 1'b0;
            phase_b_o <= 1'b0;
            index_o <= 1'b0;
        end
        else
        begin
            div <= next_div;
            pos <= next_pos;
            phase_a_o <= next_pos[1];
            phase_b_o <= next_pos[1] ^ next_pos[0];
            index_o <= (next_pos == 10'h000);
        end
    end

    a_quad_one_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        !($changed(phase_a_o) && $changed(phase_b_o)))
        else $error("both quadrature phases changed together");

endmodule

`default_nettype wire

//--- sim/asc_spi_master.sv
// behavioural mode 3 master that drives the angle sensor link pins
// assumes the bench calls xfer from one process at a time
`timescale 1ns/1ps
`default_nettype none

module asc_spi_master
(
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        mosi_o = 1'b0;
    end

    // n bits msb first from tx[23]; rx gathers the answer, last bit at rx[0]
    task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = 24'h00_0000;
        cs_n_o = 1'b0;
        #100;
        for (int i = 0; i < n; i++)
        begin
            sclk_o = 1'b0;
            mosi_o = tx[23 - i];
            #62.5;
            sclk_o = 1'b1;
            rx = {rx[22:0], miso_oe_i ? miso_i : 1'bx};
            #62.5;
        end
        cs_n_o = 1'b1;
        // released line flips so a stale bit never passes as fresh
        mosi_o = ~mosi_o;
        #100;
    endtask
endmodule

`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the angle sensor serial port
// assumes asc_top and the mode 3 master model; link clock 125 ns
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct packed
    {
        logic [15:0] angle;
        logic [7:0] tx;
        logic [7:0] ty;
    } asc_meas_t;

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cs_n, sclk, mosi, miso, miso_oe, quad_a, quad_b, quad_idx;
    logic raw_valid = 1'b0;
    logic xen = 1'b0;
    logic yen = 1'b0;
    logic [15:0] raw_angle = 16'h0000;
    logic [15:0] angle;
    logic [7:0] trim_x, trim_y;
    logic [7:0] trim_amt = 8'h00;
    logic [7:0] zh = 8'h00;
    logic [7:0] tidx = 8'h00;
    logic [3:0] zl = 4'h0;
    logic [2:0] flash;
    logic [23:0] rx;
    asc_meas_t exp_q[$];
    asc_meas_t last = '0;
    asc_meas_t mon_e;
    integer seed = 32'hf6fc_964b;
    int failures = 0;
    int cmp_count = 0;

    asc_spi_master i_master (.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

    asc_top i_dut
    (
        .REF_CLK_I(ref_clk),
        .SYS_RST_I(sys_rst),
        .SPI_CS_N_I(cs_n),
        .SPI_SCLK_I(sclk),
        .SPI_MOSI_I(mosi),
        .SPI_MISO_O(miso),
        .SPI_MISO_OE_O(miso_oe),
        .RAW_ANGLE_I(raw_angle),
        .RAW_VALID_I(raw_valid),
        .ANGLE_O(angle),
        .TRIM_X_O(trim_x),
        .TRIM_Y_O(trim_y),
        .FLASH_COMMIT_O(flash),
        .QUAD_A_O(quad_a),
        .QUAD_B_O(quad_b),
        .QUAD_INDEX_O(quad_idx)
    );

    initial
        forever #5 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // expected outputs are noted at the strobe, compared once they have landed
    task automatic measure(input logic [15:0] raw);
        @(negedge ref_clk);
        raw_angle = raw;
        raw_valid = 1'b1;
        last.angle = raw - {zh, zl, 4'h0};
        last.tx = xen ? trim_amt : 8'h00;
        last.ty = yen ? trim_amt : 8'h00;
        exp_q.push_back(last);
        tidx++;
        @(negedge ref_clk);
        raw_valid = 1'b0;
        raw_angle = 16'($random(seed));
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_master.xfer({asc_pkg::OP_WRITE, a, d, 8'h00}, 16, rx);
        repeat (6) @(negedge ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] d);
        i_master.xfer({asc_pkg::OP_READ, a, 8'h00, 8'h00}, 16, rx);
        i_master.xfer(24'h00_0000, 24, rx);
        check(rx, {d, 8'h00, tidx});
    endtask

    task automatic watch_flash(input logic [2:0] exp);
        int k;
        k = 0;
        while (flash === 3'b000 && k < 2000)
        begin
            @(negedge ref_clk);
            k++;
        end
        if (k == 2000)
        begin
            failures++;
            end_of_test();
        end
        else
        begin
            check(flash, exp);
            @(negedge ref_clk);
            check(flash, 3'b000);
        end
    endtask

    initial
    forever
    begin
        @(posedge ref_clk);
        if (raw_valid === 1'b1)
        begin
            repeat (2) @(negedge ref_clk);
            mon_e = exp_q.pop_front();
            check(angle, mon_e.angle);
            check(trim_x, mon_e.tx);
            check(trim_y, mon_e.ty);
        end
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        check({miso_oe, quad_a, quad_b, quad_idx}, 4'b0001);
        check({angle, trim_x, trim_y}, 32'h0000_0000);
        check(flash, 3'b000);
        rd(asc_pkg::ADDR_BIAS_TRIM, 8'h00);
        rd(asc_pkg::ADDR_ZERO_HIGH, 8'h00);
        rd(asc_pkg::ADDR_TRIM_ZERO_LOW, 8'h00);
        $display("test reset done");

        measure(16'($random(seed)));
        i_master.xfer(24'h00_0000, 16, rx);
        check(rx[15:0], last.angle);
        i_master.xfer(24'h00_0000, 24, rx);
        check(rx, {last.angle, tidx});
        check(miso_oe, 1'b0);
        $display("test readout done");

        // bits 7 and 6 written high to prove they read back zero
        for (int m = 0; m < 4; m++)
        begin
            trim_amt = 8'($random(seed));
            zh = 8'($random(seed));
            zl = 4'($random(seed));
            {yen, xen} = m[1:0];
            wr(asc_pkg::ADDR_BIAS_TRIM, trim_amt);
            wr(asc_pkg::ADDR_ZERO_HIGH, zh);
            wr(asc_pkg::ADDR_TRIM_ZERO_LOW, {2'b11, yen, xen, zl});
            check({trim_x, trim_y}, {last.tx, last.ty});
            measure(16'($random(seed)));
            rd(asc_pkg::ADDR_TRIM_ZERO_LOW, {2'b00, yen, xen, zl});
            rd(asc_pkg::ADDR_ZERO_HIGH, zh);
            rd(asc_pkg::ADDR_BIAS_TRIM, trim_amt);
        end
        $display("test trims done");

        rd(4'h7, 8'h00);
        rd(asc_pkg::ADDR_FLASH, 8'h00);
        i_master.xfer({asc_pkg::OP_WRITE, asc_pkg::ADDR_BIAS_TRIM, ~trim_amt, 8'h00}, 15, rx);
        // a short frame ends off the grid; realign so select never moves on a sampling edge
        @(negedge ref_clk);
        rd(asc_pkg::ADDR_BIAS_TRIM, trim_amt);
        $display("test refusals done");

        for (int n = 3; n < 6; n++)
        begin
            fork
                wr(asc_pkg::ADDR_FLASH, 8'h01 << n);
                watch_flash(3'b001 << (n - 3));
            join
        end
        $display("test flash done");

        // second pass lands on zero so the index line must rise
        for (int q = 0; q < 2; q++)
        begin
            measure(q == 0 ? 16'($random(seed)) : {zh, zl, 4'h0});
            repeat (2700) @(negedge ref_clk);
            check({quad_a, quad_b, quad_idx}, {last.angle[7], ^last.angle[7:6], last.angle[15:6] == 10'h000});
        end
        $display("test quadrature done");
        end_of_test();
    end
endmodule

`default_nettype wire
